// File: include/tc_monitor_params.svh
// Constants for the tandem connection monitor back end
`ifndef TC_MONITOR_PARAMS_SVH
`define TC_MONITOR_PARAMS_SVH
`define TC_MF_LAST 7'd75
`define TC_FAS_POS 7'd7
`define TC_MF_RESYNC 7'd8
`define TC_RDI_POS 7'd72
`define TC_ODI_POS 7'd73
`define TC_FAS_PATTERN 16'hFFFE
`define TC_FAS_ERR_LAST 2'd1
`define TC_UNEQ_LAST 3'd4
`define TC_UNEQ_CODE 8'h00
`define TC_SECOND_MS 1000
`define TC_CLK_KHZ 50000
`define TC_REG_CTRL 6'h00
`define TC_REG_DEG 6'h04
`define TC_REG_DEFECT 6'h08
`define TC_REG_CAUSE 6'h0C
`define TC_REG_PM_DS 6'h10
`define TC_REG_PM_NEBC 6'h14
`define TC_REG_PM_FEBC 6'h18
`define TC_REG_PM_OEBC 6'h1C
`define TC_REG_IRQ_ST 6'h20
`define TC_REG_IRQ_CLR 6'h24
`define TC_REG_IRQ_EN 6'h28
`define TC_CTRL_MON 0
`define TC_CTRL_TRACE_CHECK_DISABLE 1
`define TC_CTRL_SSFREP 2
`define TC_CTRL_RDIREP 3
`define TC_CTRL_ODIREP 4
`define TC_CTRL_RST 5'h00
`define TC_DEG_THR_RST 16'h0010
`define TC_DEG_M_RST 4'h3
`endif

// File: include/tc_monitor_pkg.sv
// Types for the tandem connection monitor back end
package tc_monitor_pkg;
  typedef enum logic [0:0] {
    OUT_OF_MULTIFRAME_STATE = 1'b0,
    IN_MULTIFRAME_STATE = 1'b1
  } align_state_t;
endpackage

// File: rtl/tc_monitor_defect_correlation.sv
// Tandem connection monitor: defects, correlation, per-second counts
// Functional notes
// - Loss of tandem connection defect is high exactly while aligner is out of multiframe.
// - Trace mismatch defect follows the trace condition well within one second.
// - Trace mismatch defect is forced inactive while server signal fail is high.
// - Management bit disables trace mismatch detection.
// - Signal degrade derives from per-second near-end errored block counts.
// - Remote defect taken from received remote defect bit.
// - Outgoing defect taken from received outgoing defect bit.
// - Loss cause needs monitoring, no unequipped, loss defect present.
// - Trace cause needs monitoring, no unequipped, no loss, trace defect.
// - Degrade cause needs monitoring, no trace, no loss, degrade defect.
// - Remote cause needs monitoring, no unequipped/trace/loss, remote defect, report bit.
// - Outgoing cause needs monitoring, no unequipped/trace/loss, outgoing defect, report bit.
// - Per second: defect seconds and errored block sums, near, far, outgoing.
// - Aligner searches fifteen ones then zero and keeps checking that position.
// - Two errored alignment words in a row lose alignment; one good regains it.
// - Unequipped set after five zero bytes, cleared after five non-zero bytes.
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tc_monitor_params.svh"
module tc_monitor_defect_correlation
  import tc_monitor_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = `TC_SECOND_MS * `TC_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic linkClk,
  input wire logic linkFrameStart,
  input wire logic [7:0] tcOverheadByte,
  input wire logic serverSignalFailIn,
  input wire logic traceMismatchIn,
  input wire logic nearErroredBlock,
  input wire logic farErroredBlock,
  input wire logic outgoingErroredBlock,
  input wire logic equipmentDefect,
  output logic trailFailAction,
  output logic trailDegradeAction,
  output logic irq
);
  localparam int SCW = $clog2(SECOND_CYCLES + 1);
  // ****************************************
  // Link sampling
  // ****************************************
  // All link inputs share the same two-stage delay, so data keeps
  // its relation to the sampled link clock edge.
  logic [14:0] rawIn, meta_q, sync_q;
  logic linkPrev_q, ack_q;
  assign rawIn = {linkClk, linkFrameStart, serverSignalFailIn, traceMismatchIn,
    nearErroredBlock, farErroredBlock, outgoingErroredBlock, tcOverheadByte};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
      linkPrev_q <= 1'b0;
    end else begin
      meta_q <= rawIn;
      sync_q <= meta_q;
      linkPrev_q <= sync_q[14];
    end
  end
  wire logic frameEv = sync_q[14] & ~linkPrev_q & sync_q[13];
  wire logic ssf = sync_q[12];
  wire logic [7:0] ovh = sync_q[7:0];
  wire logic [2:0] ebcIn = sync_q[10:8];
  // ****************************************
  // Registers
  // ****************************************
  logic [4:0] ctrl_q;
  logic [15:0] degThr_q;
  logic [3:0] degM_q;
  logic [1:0] irqEn_q, irqSt_q;
  logic [31:0] rdata_q, rdMux;
  function automatic logic regHit(input logic [5:0] a, input logic [5:0] off);
    return a[5:2] == off[5:2];
  endfunction
  wire logic req = avs_read | avs_write;
  wire logic wrAck = avs_write & ack_q;
  wire logic monitorEnable = ctrl_q[`TC_CTRL_MON];
  // ****************************************
  // Multiframe aligner
  // ****************************************
  align_state_t state_q, state_d;
  logic [15:0] fas_q;
  logic [6:0] mfPos_q, mfPos_d;
  logic [1:0] fasErr_q, fasErr_d;
  logic remoteDefect_q, outgoingDefect_q, unequipped_q, tsf_q, deg_q;
  wire logic [15:0] fasNext = {fas_q[13:0], ovh[1:0]};
  wire logic fasMatch = fasNext == `TC_FAS_PATTERN;
  wire logic atFas = (state_q == IN_MULTIFRAME_STATE) && (mfPos_q == `TC_FAS_POS);
  wire logic lossOfTc = state_q == OUT_OF_MULTIFRAME_STATE;
  always_comb begin
    state_d = state_q;
    fasErr_d = fasErr_q;
    mfPos_d = (mfPos_q == `TC_MF_LAST) ? '0 : mfPos_q + 7'h01;
    case (state_q)
      OUT_OF_MULTIFRAME_STATE: begin
        if (fasMatch) begin
          state_d = IN_MULTIFRAME_STATE;
          mfPos_d = `TC_MF_RESYNC;
          fasErr_d = '0;
        end
      end
      default: begin
        if (atFas) begin
          if (fasMatch) begin
            fasErr_d = '0;
          end else if (fasErr_q == `TC_FAS_ERR_LAST) begin
            state_d = OUT_OF_MULTIFRAME_STATE;
            fasErr_d = '0;
          end else begin
            fasErr_d = fasErr_q + 2'h1;
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= OUT_OF_MULTIFRAME_STATE;
      fas_q <= '0;
      mfPos_q <= '0;
      fasErr_q <= '0;
    end else if (frameEv) begin
      state_q <= state_d;
      fas_q <= fasNext;
      mfPos_q <= mfPos_d;
      fasErr_q <= fasErr_d;
    end
  end
  // Multiframed indications are only meaningful while aligned
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remoteDefect_q <= 1'b0;
      outgoingDefect_q <= 1'b0;
    end else if (lossOfTc) begin
      remoteDefect_q <= 1'b0;
      outgoingDefect_q <= 1'b0;
    end else if (frameEv && mfPos_q == `TC_RDI_POS) begin
      remoteDefect_q <= ovh[0];
    end else if (frameEv && mfPos_q == `TC_ODI_POS) begin
      outgoingDefect_q <= ovh[1];
    end
  end
  // ****************************************
  // Unequipped and trace defects
  // ****************************************
  logic [2:0] uneqCnt_q;
  wire logic isZero = ovh == `TC_UNEQ_CODE;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      uneqCnt_q <= '0;
      unequipped_q <= 1'b0;
    end else if (frameEv) begin
      if (isZero == unequipped_q) begin
        uneqCnt_q <= '0;
      end else if (uneqCnt_q == `TC_UNEQ_LAST) begin
        uneqCnt_q <= '0;
        unequipped_q <= isZero;
      end else begin
        uneqCnt_q <= uneqCnt_q + 3'h1;
      end
    end
  end
  // Follows the comparator within a few clocks, far inside one second
  wire logic traceMismatch = sync_q[11] & ~ssf & ~ctrl_q[`TC_CTRL_TRACE_CHECK_DISABLE];
  // ****************************************
  // Per-second monitoring
  // ****************************************
  logic [SCW-1:0] secCnt_q;
  wire logic secTick = secCnt_q == SCW'(SECOND_CYCLES - 1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secCnt_q <= '0;
    end else begin
      secCnt_q <= secTick ? '0 : secCnt_q + SCW'(1);
    end
  end
  logic [3:0] degCnt_q;
  wire logic tsfNow = ssf | unequipped_q | traceMismatch | lossOfTc;
  wire logic [2:0] dsIn = {outgoingDefect_q, remoteDefect_q, tsf_q | equipmentDefect};
  logic [15:0] pmEbc [3];
  logic [2:0] pmDs;
  generate
    for (genvar g = 0; g < 3; g++) begin : gPm
      logic [15:0] acc_q, pm_q;
      logic ds_q, pmDs_q;
      wire logic [15:0] accNext = acc_q + {15'h0000, frameEv & ebcIn[2-g]};
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          acc_q <= '0;
          pm_q <= '0;
          ds_q <= 1'b0;
          pmDs_q <= 1'b0;
        end else if (secTick) begin
          pm_q <= accNext;
          pmDs_q <= ds_q | dsIn[g];
          acc_q <= '0;
          ds_q <= 1'b0;
        end else begin
          acc_q <= accNext;
          ds_q <= ds_q | dsIn[g];
        end
      end
      assign pmEbc[g] = pm_q;
      assign pmDs[g] = pmDs_q;
    end
  endgenerate
  // Degrade: a second is bad when near-end errored blocks reach threshold;
  // a change needs degM_q consecutive agreeing seconds.
  wire logic badSec = gPm[0].accNext >= degThr_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      degCnt_q <= '0;
      deg_q <= 1'b0;
      tsf_q <= 1'b0;
    end else begin
      tsf_q <= tsfNow;
      if (secTick) begin
        if (badSec == deg_q) begin
          degCnt_q <= '0;
        end else if (degCnt_q + 4'h1 >= degM_q) begin
          degCnt_q <= '0;
          deg_q <= badSec;
        end else begin
          degCnt_q <= degCnt_q + 4'h1;
        end
      end
    end
  end
  assign trailFailAction = tsf_q;
  assign trailDegradeAction = deg_q;
  // ****************************************
  // Correlation and interrupts
  // ****************************************
  logic [6:0] cause, causePrev_q;
  wire logic blocked = unequipped_q | traceMismatch | lossOfTc;
  assign cause[0] = monitorEnable & unequipped_q;
  assign cause[1] = monitorEnable & ~unequipped_q & lossOfTc;
  assign cause[2] = monitorEnable & ~unequipped_q & ~lossOfTc & traceMismatch;
  assign cause[3] = monitorEnable & ~traceMismatch & ~lossOfTc & deg_q;
  assign cause[4] = monitorEnable & ssf & ctrl_q[`TC_CTRL_SSFREP];
  assign cause[5] = monitorEnable & ~blocked & remoteDefect_q & ctrl_q[`TC_CTRL_RDIREP];
  assign cause[6] = monitorEnable & ~blocked & outgoingDefect_q & ctrl_q[`TC_CTRL_ODIREP];
  wire logic [1:0] irqEv = {cause != causePrev_q, secTick};
  wire logic [1:0] irqClr = (wrAck && regHit(avs_address, `TC_REG_IRQ_CLR)) ? avs_writedata[1:0] : 2'h0;
  wire logic [9:0] defects = {state_q == IN_MULTIFRAME_STATE, deg_q, tsf_q, ssf,
    unequipped_q, outgoingDefect_q, remoteDefect_q, deg_q, traceMismatch, lossOfTc};
  always_comb begin
    rdMux = 32'h0000_0000;
    if (regHit(avs_address, `TC_REG_CTRL)) begin
      rdMux = {27'h0, ctrl_q};
    end else if (regHit(avs_address, `TC_REG_DEG)) begin
      rdMux = {12'h000, degM_q, degThr_q};
    end else if (regHit(avs_address, `TC_REG_DEFECT)) begin
      rdMux = {22'h0, defects};
    end else if (regHit(avs_address, `TC_REG_CAUSE)) begin
      rdMux = {25'h0, cause};
    end else if (regHit(avs_address, `TC_REG_PM_DS)) begin
      rdMux = {29'h0, pmDs};
    end else if (regHit(avs_address, `TC_REG_PM_NEBC)) begin
      rdMux = {16'h0000, pmEbc[0]};
    end else if (regHit(avs_address, `TC_REG_PM_FEBC)) begin
      rdMux = {16'h0000, pmEbc[1]};
    end else if (regHit(avs_address, `TC_REG_PM_OEBC)) begin
      rdMux = {16'h0000, pmEbc[2]};
    end else if (regHit(avs_address, `TC_REG_IRQ_ST)) begin
      rdMux = {30'h0, irqSt_q};
    end else if (regHit(avs_address, `TC_REG_IRQ_EN)) begin
      rdMux = {30'h0, irqEn_q};
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
      ctrl_q <= `TC_CTRL_RST;
      degThr_q <= `TC_DEG_THR_RST;
      degM_q <= `TC_DEG_M_RST;
      irqEn_q <= '0;
      irqSt_q <= '0;
      causePrev_q <= '0;
    end else begin
      ack_q <= req & ~ack_q;
      causePrev_q <= cause;
      irqSt_q <= (irqSt_q & ~irqClr) | irqEv; // Set wins over clear
      if (avs_read && !ack_q) begin
        rdata_q <= rdMux;
      end
      if (wrAck && regHit(avs_address, `TC_REG_CTRL)) begin
        ctrl_q <= avs_writedata[4:0];
      end
      if (wrAck && regHit(avs_address, `TC_REG_DEG)) begin
        degThr_q <= avs_writedata[15:0];
        degM_q <= avs_writedata[19:16];
      end
      if (wrAck && regHit(avs_address, `TC_REG_IRQ_EN)) begin
        irqEn_q <= avs_writedata[1:0];
      end
    end
  end
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;
  assign irq = |(irqSt_q & irqEn_q);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence fasLastBad;
    frameEv && atFas && !fasMatch && fasErr_q == `TC_FAS_ERR_LAST;
  endsequence
  sequence fasFound;
    frameEv && lossOfTc && fasMatch;
  endsequence
  sequence busReq;
    req && !ack_q;
  endsequence
  a_ltc_enter: assert property (fasLastBad |=> lossOfTc) else $error("alignment not lost");
  a_ltc_leave: assert property (fasFound |=> !lossOfTc ##0 cause[1] == 1'b0) else $error("loss not cleared");
  a_uneq_set: assert property (frameEv && isZero && !unequipped_q && uneqCnt_q == `TC_UNEQ_LAST
    |=> unequipped_q) else $error("unequipped not set");
  a_tim_ssf: assert property (ssf |-> !traceMismatch && !cause[2]) else $error("trace defect during fail");
  a_tim_dis: assert property (ctrl_q[`TC_CTRL_TRACE_CHECK_DISABLE] |-> !traceMismatch) else $error("trace not disabled");
  a_cause_mon: assert property (!monitorEnable |-> cause == 7'h00) else $error("cause without monitor");
  a_rdi_block: assert property (blocked |-> !cause[5] && !cause[6]) else $error("remote cause not masked");
  a_tsf_follow: assert property (tsfNow |=> trailFailAction) else $error("trail fail missing");
  a_pm_latch: assert property (secTick |=> pmEbc[0] == $past(gPm[0].accNext)) else $error("count not latched");
  a_bus_ack: assert property (busReq |-> avs_waitrequest ##1 !avs_waitrequest) else $error("no bus answer");
endmodule
`default_nettype wire

// File: tb/tc_link_source.sv
// Far-end tandem connection source model driving the link side of the monitor
`timescale 1ns/10ps
`default_nettype none
module tc_link_source (
  input wire logic fasErr,
  input wire logic zeroByte,
  input wire logic remoteBit,
  input wire logic outgoingBit,
  output logic linkClk,
  output logic linkFrameStart,
  output logic [7:0] tcOverheadByte
);
  // ****
  // Multiframe generator
  // ****
  int idx;
  // Filler frames carry 01 so no false alignment word can appear
  function automatic logic [1:0] mf_bits(input int i);
    if (i == 3 && fasErr) return 2'b00;
    if (i < 7) return 2'b11;
    if (i == 7) return 2'b10;
    if (i == 72) return {1'b0, remoteBit};
    if (i == 73) return {outgoingBit, 1'b0};
    return 2'b01;
  endfunction
  // Frames are continuous, so the link clock runs free; data moves on the falling edge
  initial begin
    idx = 0;
    linkClk = 1'b0;
    linkFrameStart = 1'b1;
    tcOverheadByte = 8'hB7;
    #37;
    forever begin
      #80;
      linkClk = 1'b1;
      #80;
      linkClk = 1'b0;
      idx = (idx + 1) % 76;
      tcOverheadByte = zeroByte ? 8'h00 : {6'h2D, mf_bits(idx)};
    end
  end
endmodule
`default_nettype wire

// File: tb/tc_monitor_defect_correlation_tb_top.sv
// Self-checking bench for the tandem connection monitor back end
`timescale 1ns/10ps
`default_nettype none
`include "tc_monitor_params.svh"
module tc_monitor_defect_correlation_tb_top;
  // ****
  // Environment
  // ****
  localparam logic [5:0] DEF = `TC_REG_DEFECT;
  localparam logic [5:0] CAU = `TC_REG_CAUSE;
  logic clk, linkClk, linkFrameStart, avsWaitrequest, tfa, tda, irq;
  logic rstn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, ssf = 1'b0, trace = 1'b0, eqDef = 1'b0;
  logic nearEb = 1'b0, farEb = 1'b0, outEb = 1'b0, fasErr = 1'b0, zeroByte = 1'b0;
  logic remoteBit = 1'b0, outgoingBit = 1'b0;
  logic [5:0] avsAddress = 6'h00;
  logic [31:0] avsWritedata = 32'h0, avsReaddata;
  logic [7:0] ovhByte;
  int failCount, checked, cycles;
  tc_monitor_defect_correlation #(.SECOND_CYCLES(200)) dut (.clk(clk), .rstn(rstn), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .linkClk(linkClk), .linkFrameStart(linkFrameStart),
    .tcOverheadByte(ovhByte), .serverSignalFailIn(ssf), .traceMismatchIn(trace), .nearErroredBlock(nearEb),
    .farErroredBlock(farEb), .outgoingErroredBlock(outEb), .equipmentDefect(eqDef),
    .trailFailAction(tfa), .trailDegradeAction(tda), .irq(irq));
  tc_link_source src (.fasErr(fasErr), .zeroByte(zeroByte), .remoteBit(remoteBit), .outgoingBit(outgoingBit),
    .linkClk(linkClk), .linkFrameStart(linkFrameStart), .tcOverheadByte(ovhByte));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failCount++;
      $display("[FAIL] %0t timeout", $time);
      completeRun();
    end
  end
  task automatic completeRun();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle cycle at the end so back-to-back calls never assign a strobe twice in one step
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    // Exactly one wait cycle: the answer comes at the second edge
    cmp(n, 32'd2);
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // Polls up to the given number of reads, then compares the masked value
  task automatic chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input int tries);
    logic [31:0] q;
    repeat (tries) begin
      bus(1'b0, a, 32'h0, q);
      if ((q & m) === e) break;
    end
    cmp(q & m, e);
  endtask
  task automatic frames(input int n);
    repeat (n) @(negedge linkClk);
    @(posedge clk);
  endtask
  task automatic toIdx(input int n);
    do frames(1); while (src.idx != n);
  endtask
  task automatic waitIrq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, irq}, 32'h1);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic resetValues();
    chk(DEF, 32'h201, 32'h001, 1);
    chk(`TC_REG_CTRL, 32'hFFFF_FFFF, 32'h0, 1);
    chk(`TC_REG_DEG, 32'hFFFF_FFFF, 32'h0003_0010, 1);
    wr(6'h3C, 32'hFFFF_FFFF);
    chk(6'h3C, 32'hFFFF_FFFF, 32'h0, 1);
    wr(CAU, 32'h7F);
    chk(CAU, 32'h7F, 32'h0, 1);
    cmp({31'h0, irq}, 32'h0);
  endtask
  task automatic alignment();
    chk(DEF, 32'h201, 32'h200, 400);
    cmp({31'h0, tfa}, 32'h0);
    wr(`TC_REG_CTRL, 32'h1D);
    toIdx(10);
    fasErr <= 1'b1;
    toIdx(10);
    fasErr <= 1'b0;
    toIdx(10);
    fasErr <= 1'b1;
    toIdx(10);
    chk(DEF, 32'h201, 32'h200, 1);
    toIdx(10);
    chk(DEF, 32'h201, 32'h001, 1);
    chk(CAU, 32'h7F, 32'h02, 1);
    cmp({31'h0, tfa}, 32'h1);
    wr(`TC_REG_CTRL, 32'h1C);
    chk(CAU, 32'h7F, 32'h0, 1);
    fasErr <= 1'b0;
    wr(`TC_REG_CTRL, 32'h1D);
    toIdx(10);
    chk(DEF, 32'h201, 32'h200, 1);
  endtask
  task automatic unequipped();
    frames(1);
    zeroByte <= 1'b1;
    frames(5);
    chk(DEF, 32'h20, 32'h0, 1);
    frames(1);
    chk(DEF, 32'h20, 32'h20, 1);
    chk(CAU, 32'h3, 32'h1, 1);
    cmp({31'h0, tfa}, 32'h1);
    frames(1);
    zeroByte <= 1'b0;
    frames(5);
    chk(DEF, 32'h20, 32'h20, 1);
    frames(1);
    chk(DEF, 32'h20, 32'h0, 1);
    chk(DEF, 32'h201, 32'h200, 400);
  endtask
  task automatic traceAndRemote();
    trace <= 1'b1;
    remoteBit <= 1'b1;
    outgoingBit <= 1'b1;
    chk(DEF, 32'h2, 32'h2, 60);
    toIdx(75);
    chk(DEF, 32'h18, 32'h18, 1);
    chk(CAU, 32'h66, 32'h04, 1);
    cmp({31'h0, tfa}, 32'h1);
    ssf <= 1'b1;
    chk(DEF, 32'h2, 32'h0, 20);
    chk(CAU, 32'h10, 32'h10, 1);
    ssf <= 1'b0;
    wr(`TC_REG_CTRL, 32'h1F);
    chk(DEF, 32'h2, 32'h0, 1);
    chk(CAU, 32'h66, 32'h60, 1);
    wr(`TC_REG_CTRL, 32'h03);
    chk(CAU, 32'h60, 32'h0, 1);
    remoteBit <= 1'b0;
    outgoingBit <= 1'b0;
    trace <= 1'b0;
    wr(`TC_REG_CTRL, 32'h01);
    toIdx(75);
    chk(DEF, 32'h1A, 32'h0, 1);
  endtask
  task automatic perSecond();
    wr(`TC_REG_IRQ_EN, 32'h1);
    wr(`TC_REG_IRQ_CLR, 32'h1);
    // A fresh boundary keeps the error burst inside one second
    waitIrq();
    chk(`TC_REG_IRQ_ST, 32'h1, 32'h1, 1);
    wr(`TC_REG_IRQ_CLR, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    frames(1);
    nearEb <= 1'b1;
    farEb <= 1'b1;
    outEb <= 1'b1;
    eqDef <= 1'b1;
    frames(5);
    outEb <= 1'b0;
    eqDef <= 1'b0;
    frames(5);
    nearEb <= 1'b0;
    farEb <= 1'b0;
    waitIrq();
    chk(`TC_REG_PM_NEBC, 32'hFFFF, 32'hA, 1);
    chk(`TC_REG_PM_FEBC, 32'hFFFF, 32'hA, 1);
    chk(`TC_REG_PM_OEBC, 32'hFFFF, 32'h5, 1);
    chk(`TC_REG_PM_DS, 32'h7, 32'h1, 1);
    wr(`TC_REG_IRQ_EN, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    chk(`TC_REG_IRQ_ST, 32'h1, 32'h1, 1);
  endtask
  task automatic degrade();
    wr(`TC_REG_DEG, 32'h0001_0001);
    nearEb <= 1'b1;
    chk(DEF, 32'h4, 32'h4, 300);
    cmp({31'h0, tda}, 32'h1);
    chk(CAU, 32'h8, 32'h8, 1);
    trace <= 1'b1;
    chk(CAU, 32'hC, 32'h4, 20);
    trace <= 1'b0;
    nearEb <= 1'b0;
    chk(DEF, 32'h4, 32'h0, 300);
    cmp({31'h0, tda}, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    resetValues();
    alignment();
    unequipped();
    traceAndRemote();
    perSecond();
    degrade();
    completeRun();
  end
endmodule
`default_nettype wire
